// ===== design/burner_pos_pkg.sv
package burner_pos_pkg;
    // Channel numbering and widths
    localparam int         CH_N       = 6;
    localparam int         PW         = 10;
    localparam logic [2:0] CH_AIR     = 3'h0;
    localparam logic [2:0] CH_GAS     = 3'h1;
    localparam logic [2:0] CH_OIL     = 3'h2;
    localparam logic [2:0] CH_AUX     = 3'h3;
    localparam logic [2:0] CH_RECIRC  = 3'h4;
    localparam logic [2:0] CH_FAN     = 3'h5;
    // Channels that control air: air, auxiliary, recirculation, fan
    localparam logic [CH_N-1:0] AIR_CTRL_MASK = 6'h39;
    // Position sets held in the target table
    localparam logic [2:0] SET_HOME    = 3'h0;
    localparam logic [2:0] SET_PURGE   = 3'h1;
    localparam logic [2:0] SET_IGNITE  = 3'h2;
    localparam logic [2:0] SET_START   = 3'h3;
    localparam logic [2:0] SET_MINLOAD = 3'h4;
    // Auxiliary drive setting values
    localparam logic [2:0] AUX_OFF        = 3'h0;
    localparam logic [2:0] AUX_MIX        = 3'h1;
    localparam logic [2:0] AUX_FAN        = 3'h2;
    localparam logic [2:0] AUX_RECIRC     = 3'h3;
    localparam logic [2:0] AUX_FAN_RECIRC = 3'h4;
    // Register byte offsets
    localparam logic [11:0] ADDR_CFG  = 12'h000;
    localparam logic [11:0] ADDR_ROT  = 12'h004;
    localparam logic [11:0] ADDR_LOAD = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [2:0]  TBL_PAGE  = 3'h1;
    localparam logic [2:0]  SIZE_WORD = 3'h2;
    // Field positions
    localparam int CFG_AIR_ON = 0;
    localparam int CFG_GAS_ON = 1;
    localparam int CFG_OIL_ON = 2;
    localparam int CFG_GAUX   = 3;
    localparam int CFG_OAUX   = 4;
    localparam int CFG_SEL    = 5;
    localparam int CFG_CNT    = 8;
    localparam int CFG_AFF    = 10;
    localparam int CFG_GLATE  = 16;
    localparam int CFG_OLATE  = 17;
    localparam int CFG_GPILOT = 18;
    localparam int CFG_OPILOT = 19;
    localparam int ROT_ERASE  = 8;
    localparam int LD_START   = 0;
    localparam int LD_GMIN    = 4;
    localparam int LD_OMIN    = 8;
    localparam int LD_TMAX    = 16;
    // Values after reset
    localparam logic [31:0] CFG_RST  = 32'h0000_0207;
    localparam logic [31:0] LOAD_RST = 32'h0032_0000;
    // Burner control phases
    localparam logic [6:0] PH_PURGE = 7'h18;
    localparam logic [6:0] PH_IGNITE = 7'h24;
    localparam logic [6:0] PH_LOW_EARLY = 7'h32;
    localparam logic [6:0] PH_LOW_LATE = 7'h36;
    // Position limits in 0.1 degree or 0.1 percent
    localparam logic [PW-1:0] DAMPER_MAX = 10'h384;
    localparam logic [PW-1:0] FAN_MAX    = 10'h3e8;
    localparam logic [PW-1:0] FAN_MIN    = 10'h064;
    localparam logic [PW-1:0] POS_TOL    = 10'h014;
    // Timing
    localparam int CLK_NS      = 100;
    localparam int TICK_NS     = 100_000_000;
    localparam int STEP_NS     = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int STEP_CYCLES = STEP_NS / CLK_NS;
    // Sequencer states, Gray along the start path through minimum load (START to RUN changes two bits)
    typedef enum logic [2:0] {
        ST_HOME    = 3'h0,
        ST_PURGE   = 3'h1,
        ST_IGNITE  = 3'h3,
        ST_START   = 3'h2,
        ST_MINLOAD = 3'h6,
        ST_RUN     = 3'h7
    } pos_state_t;
endpackage

// ===== design/burner_actuator_phase_positioner.sv
// The AHB-Lite register port and the address map were chosen for this implementation.
module burner_actuator_phase_positioner
    import burner_pos_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int STEP_CYC = STEP_CYCLES
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic [6:0]              phase_code,
    input  wire logic                    fuel_oil,
    input  wire logic                    flame_stable,
    input  wire logic                    speed_std,
    input  wire logic [CH_N-1:0][PW-1:0] pos_fb,
    output logic      [CH_N-1:0][PW-1:0] pos_cmd,
    output logic      [CH_N-1:0]         cmd_valid,
    output logic                         phase_ready,
    output logic                         purge_timer_go,
    output logic                         ignition_release,
    output logic                         start_block,
    output logic                         safety_shutdown
);
    // Parameter check
    if (TICK_CYC < 1 || STEP_CYC < 1 || STEP_CYC > 16384 || TICK_CYC > 2**24) begin : g_chk
        $error("Tick or step cycle count out of range");
    end

    logic [31:0]            cfg_r;
    logic [31:0]            load_r;
    logic [CH_N-1:0]        rot_r;
    logic                   curves_empty_r;
    logic [PW-1:0]          tbl_r [0:127];
    logic                   wr_pend_r;
    logic [11:0]            wr_addr_r;
    logic [31:0]            rd_nxt;
    logic [CH_N-1:0][PW-1:0] fb_m_r;
    logic [CH_N-1:0][PW-1:0] fb_s_r;
    pos_state_t             state_r;
    pos_state_t             state_nxt;
    logic                   ent_r;
    logic                   two_fuel;
    logic                   aux_on;
    logic [2:0]             aux_sel;
    logic                   late;
    logic                   pilot;
    logic                   go_min;
    logic [CH_N-1:0]        active;
    logic [CH_N-1:0]        air_aff;
    logic [2:0]             ch_set [CH_N];
    logic [CH_N-1:0][PW-1:0] tgt_ph;
    logic [CH_N-1:0][PW-1:0] dist_r;
    logic [CH_N-1:0][PW:0]  acc_r;
    logic [CH_N-1:0]        up_r;
    logic [CH_N-1:0]        reach;
    logic [PW-1:0]          dmax_nxt;
    logic [PW-1:0]          dmax_r;
    logic [PW-1:0]          n_r;
    logic [13:0]            stp_r;
    logic                   step;
    logic                   mv_busy_r;
    logic                   ramp_st;
    logic                   all_rch;
    logic [23:0]            pre_r;
    logic [7:0]             tsec_r;
    logic                   superv;
    logic                   tmo;

    // Bus address phase capture; zero wait, always OKAY
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= hsel && htrans[1] && hready && hwrite && hsize == SIZE_WORD
                         && haddr[31:12] == 20'h00000;
            wr_addr_r <= haddr[11:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (haddr[31:12] == 20'h00000) begin
            if (haddr[11:9] == TBL_PAGE) begin
                rd_nxt = {22'h000000, tbl_r[haddr[8:2]]};
            end else begin
                case (haddr[11:0])
                    ADDR_CFG:  rd_nxt = cfg_r;
                    ADDR_ROT:  rd_nxt = {26'h0000000, rot_r};
                    ADDR_LOAD: rd_nxt = load_r;
                    ADDR_STAT: rd_nxt = {25'h0000000, curves_empty_r, safety_shutdown,
                                         start_block, all_rch, state_r};
                    default:   rd_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_r  <= CFG_RST;
            load_r <= LOAD_RST;
            rot_r  <= '0;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                ADDR_CFG:  cfg_r <= {12'h000, hwdata[19:0]};
                ADDR_LOAD: load_r <= {8'h00, hwdata[23:16], 4'h0, hwdata[11:0]};
                ADDR_ROT:  if (curves_empty_r) rot_r <= hwdata[CH_N-1:0];
                default:   ;
            endcase
        end
    end

    // Target table with curve erase
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < 128; i++) begin
                tbl_r[i] <= '0;
            end
            curves_empty_r <= 1'b1;
        end else if (wr_pend_r && wr_addr_r == ADDR_ROT && hwdata[ROT_ERASE]) begin
            for (int i = 0; i < 128; i++) begin
                if (3'(i >> 3) >= SET_IGNITE) begin
                    tbl_r[i] <= '0;
                end
            end
            curves_empty_r <= 1'b1;
        end else if (wr_pend_r && wr_addr_r[11:9] == TBL_PAGE) begin
            tbl_r[wr_addr_r[8:2]] <= hwdata[PW-1:0];
            if (wr_addr_r[7:5] >= SET_IGNITE) begin
                curves_empty_r <= 1'b0;
            end
        end
    end

    // Feedback synchroniser
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fb_m_r <= '0;
            fb_s_r <= '0;
        end else begin
            fb_m_r <= pos_fb;
            fb_s_r <= fb_m_r;
        end
    end

    // Activation and fuel settings
    always_comb begin
        two_fuel = cfg_r[CFG_CNT +: 2] != 2'h1;
        aux_on   = fuel_oil ? cfg_r[CFG_OAUX] : cfg_r[CFG_GAUX];
        aux_sel  = cfg_r[CFG_SEL +: 3];
        late     = fuel_oil ? cfg_r[CFG_OLATE] : cfg_r[CFG_GLATE];
        pilot    = fuel_oil ? cfg_r[CFG_OPILOT] : cfg_r[CFG_GPILOT];
        go_min   = (fuel_oil ? load_r[LD_OMIN +: 4] : load_r[LD_GMIN +: 4])
                   > load_r[LD_START +: 4];
        air_aff  = cfg_r[CFG_AFF +: CH_N];
        active[CH_AIR]    = cfg_r[CFG_AIR_ON];
        active[CH_GAS]    = cfg_r[CFG_GAS_ON] && (!fuel_oil || !two_fuel);
        active[CH_OIL]    = cfg_r[CFG_OIL_ON] && fuel_oil && two_fuel;
        active[CH_AUX]    = aux_on && aux_sel == AUX_MIX;
        active[CH_RECIRC] = aux_on && (aux_sel == AUX_RECIRC || aux_sel == AUX_FAN_RECIRC);
        active[CH_FAN]    = aux_on && (aux_sel == AUX_FAN || aux_sel == AUX_FAN_RECIRC);
    end

    // Per-channel target: set by state, entry by fuel, then limit and sense
    always_comb begin
        logic [PW-1:0] raw;
        logic [PW-1:0] lim;
        raw = '0;
        lim = '0;
        for (int c = 0; c < CH_N; c++) begin
            ch_set[c] = SET_HOME;
            unique case (state_r)
                ST_HOME:    ch_set[c] = (speed_std && air_aff[c]) ? SET_PURGE : SET_HOME;
                ST_PURGE:   ch_set[c] = AIR_CTRL_MASK[c] ? SET_PURGE : SET_HOME;
                ST_IGNITE:  ch_set[c] = SET_IGNITE;
                ST_START:   ch_set[c] = SET_START;
                ST_MINLOAD: ch_set[c] = SET_MINLOAD;
                ST_RUN:     ch_set[c] = go_min ? SET_MINLOAD : SET_START;
            endcase
            raw = tbl_r[{fuel_oil, ch_set[c], 3'(c)}];
            if (3'(c) == CH_FAN) begin
                lim = raw > FAN_MAX ? FAN_MAX : raw;
                tgt_ph[c] = (lim != '0 && lim < FAN_MIN) ? FAN_MIN : lim;
            end else begin
                lim = raw > DAMPER_MAX ? DAMPER_MAX : raw;
                tgt_ph[c] = rot_r[c] ? DAMPER_MAX - lim : lim;
            end
            if (!active[c]) begin
                tgt_ph[c] = '0;
            end
        end
    end

    // Position reached per channel; inactive drives count as reached
    always_comb begin
        dmax_nxt = '0;
        for (int c = 0; c < CH_N; c++) begin
            reach[c] = !active[c] || (fb_s_r[c] >= pos_cmd[c] ? fb_s_r[c] - pos_cmd[c]
                       : pos_cmd[c] - fb_s_r[c]) <= POS_TOL;
            if (active[c] && (tgt_ph[c] >= pos_cmd[c] ? tgt_ph[c] - pos_cmd[c]
                              : pos_cmd[c] - tgt_ph[c]) > dmax_nxt) begin
                dmax_nxt = tgt_ph[c] >= pos_cmd[c] ? tgt_ph[c] - pos_cmd[c]
                           : pos_cmd[c] - tgt_ph[c];
            end
        end
    end

    assign ramp_st = state_r == ST_START || state_r == ST_MINLOAD || state_r == ST_RUN;
    assign step    = stp_r == 14'(STEP_CYC - 1);
    assign all_rch = (&reach) && !mv_busy_r;

    // Commanded positions; ramps share one step count so all arrive together
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pos_cmd <= '0;
            dist_r  <= '0;
            acc_r   <= '0;
            up_r    <= '0;
        end else begin
            for (int c = 0; c < CH_N; c++) begin
                if (!active[c]) begin
                    pos_cmd[c] <= '0;
                end else if (!ramp_st) begin
                    pos_cmd[c] <= tgt_ph[c];
                end else if (ent_r) begin
                    dist_r[c] <= tgt_ph[c] >= pos_cmd[c] ? tgt_ph[c] - pos_cmd[c]
                                 : pos_cmd[c] - tgt_ph[c];
                    up_r[c]   <= tgt_ph[c] >= pos_cmd[c];
                    acc_r[c]  <= '0;
                end else if (mv_busy_r && step) begin
                    if (acc_r[c] + {1'b0, dist_r[c]} >= {1'b0, dmax_r}) begin
                        acc_r[c]   <= acc_r[c] + {1'b0, dist_r[c]} - {1'b0, dmax_r};
                        pos_cmd[c] <= up_r[c] ? pos_cmd[c] + 10'h001 : pos_cmd[c] - 10'h001;
                    end else begin
                        acc_r[c] <= acc_r[c] + {1'b0, dist_r[c]};
                    end
                end
            end
        end
    end

    // Ramp step pacing and completion
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !ramp_st) begin
            mv_busy_r <= 1'b0;
            dmax_r    <= '0;
            n_r       <= '0;
            stp_r     <= '0;
        end else if (ent_r) begin
            mv_busy_r <= dmax_nxt != '0;
            dmax_r    <= dmax_nxt;
            n_r       <= '0;
            stp_r     <= '0;
        end else if (mv_busy_r) begin
            stp_r <= step ? 14'h0000 : stp_r + 14'h0001;
            if (step) begin
                n_r <= n_r + 10'h001;
                if (n_r + 10'h001 == dmax_r) begin
                    mv_busy_r <= 1'b0;
                end
            end
        end
    end

    // Maximum time supervision in purge and ignition
    assign superv = (state_r == ST_PURGE || state_r == ST_IGNITE) && !ent_r && !all_rch;
    assign tmo    = superv && tsec_r >= load_r[LD_TMAX +: 8];

    always_ff @(posedge clk_sys) begin
        if (!reset_n || ent_r) begin
            pre_r  <= '0;
            tsec_r <= '0;
        end else if (superv) begin
            pre_r <= pre_r == 24'(TICK_CYC - 1) ? 24'h000000 : pre_r + 24'h000001;
            if (pre_r == 24'(TICK_CYC - 1) && tsec_r != 8'hff) begin
                tsec_r <= tsec_r + 8'h01;
            end
        end
    end

    // Safety shutdown; held until burner control returns below purge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            safety_shutdown <= 1'b0;
        end else if (tmo) begin
            safety_shutdown <= 1'b1;
        end else if (phase_code < PH_PURGE) begin
            safety_shutdown <= 1'b0;
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HOME: begin
                if (phase_code == PH_PURGE) state_nxt = ST_PURGE;
            end
            ST_PURGE: begin
                if (phase_code == PH_IGNITE) state_nxt = ST_IGNITE;
            end
            ST_IGNITE: begin
                if (flame_stable && ignition_release && (phase_code == PH_LOW_LATE
                    || (phase_code == PH_LOW_EARLY && !(pilot && late)))) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                if (!ent_r && all_rch) state_nxt = go_min ? ST_MINLOAD : ST_RUN;
            end
            ST_MINLOAD: begin
                if (!ent_r && all_rch) state_nxt = ST_RUN;
            end
            ST_RUN: ;
        endcase
        if (phase_code < PH_PURGE || safety_shutdown) begin
            state_nxt = ST_HOME;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_HOME;
            ent_r   <= 1'b1;
        end else begin
            state_r <= state_nxt;
            ent_r   <= state_nxt != state_r;
        end
    end

    // Status outputs to the burner control and drives
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            phase_ready      <= 1'b0;
            purge_timer_go   <= 1'b0;
            ignition_release <= 1'b0;
            start_block      <= 1'b1;
            cmd_valid        <= '0;
        end else begin
            phase_ready      <= all_rch && !ent_r;
            purge_timer_go   <= state_r == ST_PURGE && all_rch && !ent_r;
            ignition_release <= state_r == ST_IGNITE && all_rch && !ent_r;
            start_block      <= state_r == ST_HOME && !(all_rch && !ent_r);
            cmd_valid        <= active;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_purge_ok;
        state_r == ST_PURGE && all_rch && !ent_r;
    endsequence
    sequence s_ign_ok;
        state_r == ST_IGNITE && all_rch && !ent_r;
    endsequence
    sequence s_early_wait;
        state_r == ST_IGNITE && pilot && late && phase_code == PH_LOW_EARLY;
    endsequence

    a_purge_timer_go: assert property (purge_timer_go |-> $past(state_r == ST_PURGE && all_rch))
        else $error("Purge timer released before targets reached");
    a_purge_go_follow: assert property (s_purge_ok |=> purge_timer_go)
        else $error("Purge timer not released after targets reached");
    a_ign_release: assert property (s_ign_ok |=> ignition_release ##0 state_r != ST_HOME
                                    || phase_code < PH_PURGE || safety_shutdown)
        else $error("Ignition release missing");
    a_ign_gate: assert property ($rose(ignition_release) |-> $past(&reach, 1))
        else $error("Ignition released with drive off target");
    a_fuel_home: assert property (state_r == ST_PURGE |-> ch_set[CH_GAS] == SET_HOME
                                  && ch_set[CH_OIL] == SET_HOME)
        else $error("Fuel drive moved during purge");
    a_fuel_exclusive: assert property (!(cmd_valid[CH_GAS] && cmd_valid[CH_OIL]))
        else $error("Gas and oil drives commanded together");
    a_inactive_zero: assert property (!active[CH_AUX] ##1 !active[CH_AUX] |-> pos_cmd[CH_AUX] == '0)
        else $error("Deactivated drive commanded");
    a_damper_range: assert property (pos_cmd[CH_AIR] <= DAMPER_MAX && pos_cmd[CH_FAN] <= FAN_MAX)
        else $error("Command out of range");
    a_timeout_trip: assert property (tmo && state_r == ST_PURGE |=> safety_shutdown)
        else $error("Timeout did not shut down");
    a_home_no_lock: assert property (state_r == ST_HOME && !safety_shutdown |=> !safety_shutdown)
        else $error("Home deviation caused shutdown");
    a_early_hold: assert property (s_early_wait |=> state_r != ST_START)
        else $error("Late low fire left ignition in early phase");
    a_ramp_arrive: assert property ($fell(mv_busy_r) && ramp_st |-> pos_cmd == tgt_ph)
        else $error("Ramp ended off target");
endmodule

// ===== verification/servo_drive_model.sv
module servo_drive_model
    import burner_pos_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    stall,
    input  wire logic [CH_N-1:0][PW-1:0] pos_cmd,
    output logic      [CH_N-1:0][PW-1:0] pos_fb
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pos_fb = '0;
    // Each drive slews 8 counts a cycle toward its command; a stalled drive freezes
    always @(posedge clk_sys) begin
        for (int i = 0; i < CH_N; i++) begin
            if (stall) begin
                pos_fb[i] <= pos_fb[i];
            end else if (pos_fb[i] + 8 < pos_cmd[i]) begin
                pos_fb[i] <= pos_fb[i] + 10'h008;
            end else if (pos_fb[i] > pos_cmd[i] + 8) begin
                pos_fb[i] <= pos_fb[i] - 10'h008;
            end else begin
                pos_fb[i] <= pos_cmd[i];
            end
        end
    end
endmodule

// ===== verification/tb_top.sv
module tb_top import burner_pos_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk_sys = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    hsel = 1'b0;
    logic                    hwrite = 1'b0;
    logic                    fuel_oil = 1'b0;
    logic                    stall = 1'b0;
    logic                    flame_stable = 1'b0;
    logic                    speed_std = 1'b0;
    logic [1:0]              htrans = 2'h0;
    logic [6:0]              phase_code = 7'h00;
    logic [31:0]             haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h0000_7af2;
    logic [CH_N-1:0][PW-1:0] pos_fb, pos_cmd;
    logic [CH_N-1:0]         cmd_valid;
    logic hreadyout, hresp, phase_ready, purge_timer_go, ignition_release, start_block;
    logic safety_shutdown;
    int   tbl[128];
    int   mismatches = 0;
    int   tests_run = 0;
    burner_actuator_phase_positioner #(.TICK_CYC(10), .STEP_CYC(2)) dut (.clk_sys(clk_sys),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(SIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .phase_code(phase_code), .fuel_oil(fuel_oil),
        .flame_stable(flame_stable), .speed_std(speed_std), .pos_fb(pos_fb), .pos_cmd(pos_cmd),
        .cmd_valid(cmd_valid), .phase_ready(phase_ready), .purge_timer_go(purge_timer_go),
        .ignition_release(ignition_release), .start_block(start_block),
        .safety_shutdown(safety_shutdown));
    servo_drive_model servo (.clk_sys(clk_sys), .stall(stall), .pos_cmd(pos_cmd),
        .pos_fb(pos_fb));
    always #50 clk_sys = ~clk_sys;
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % 901);
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, g, e);
        end
    endtask
    // Single AHB-Lite transfer: address phase held until hready, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wait_for(ref logic s);
        for (int n = 0; n < 5000 && s !== 1'b1; n++) @(posedge clk_sys);
        if (s !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t wait timed out", $time);
        end
    endtask
    // Expected command per channel from the model table, phase set and fuel
    task automatic check_cmds(input int s);
        logic [5:0] act;
        int e;
        act = fuel_oil ? 6'h0d : 6'h0b;
        for (int c = 0; c < CH_N; c++) begin
            e = (s == 1 && !AIR_CTRL_MASK[c]) ? 0 : s;
            e = (s == 0 && speed_std && c == int'(CH_AIR)) ? 1 : e;
            e = act[c] ? tbl[int'(fuel_oil) * 64 + e * 8 + c] : 0;
            cmp(32'(pos_cmd[c]), e);
        end
        cmp(32'(cmd_valid), 32'(act));
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #3_000_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, 32'(ADDR_CFG), 32'h0, rd);
        cmp(rd, CFG_RST);
        xfer(1'b0, 32'(ADDR_LOAD), 32'h0, rd);
        cmp(rd, LOAD_RST);
        xfer(1'b0, 32'h0000_1000, 32'h0, rd);
        cmp(rd, 32'h0);
        xfer(1'b1, 32'(ADDR_CFG), 32'h000a_063f, rd);
        xfer(1'b1, 32'(ADDR_LOAD), 32'h0032_0010, rd);
        for (int i = 0; i < 128; i++) begin
            if (i % 64 < 40) begin
                tbl[i] = xs();
                xfer(1'b1, 32'h200 + 32'(i * 4), 32'(tbl[i]), rd);
            end
        end
        for (int f = 0; f < 2; f++) begin
            fuel_oil <= f[0];
            phase_code <= 7'h00;
            repeat (6) @(posedge clk_sys);
            wait_for(phase_ready);
            check_cmds(0);
            speed_std <= 1'b1;
            repeat (6) @(posedge clk_sys);
            check_cmds(0);
            speed_std <= 1'b0;
            phase_code <= PH_PURGE;
            repeat (6) @(posedge clk_sys);
            wait_for(purge_timer_go);
            check_cmds(1);
            phase_code <= PH_IGNITE;
            repeat (6) @(posedge clk_sys);
            wait_for(ignition_release);
            check_cmds(2);
            flame_stable <= 1'b1;
            phase_code <= PH_LOW_EARLY;
            repeat (20) @(posedge clk_sys);
            if (f == 1) check_cmds(2);
            phase_code <= PH_LOW_LATE;
            repeat (6) @(posedge clk_sys);
            wait_for(phase_ready);
            check_cmds(3);
            if (f == 0) begin
                repeat (6) @(posedge clk_sys);
                wait_for(phase_ready);
                check_cmds(4);
            end
            flame_stable <= 1'b0;
        end
        phase_code <= 7'h00;
        xfer(1'b1, 32'(ADDR_ROT), 32'h0000_003f, rd);
        xfer(1'b0, 32'(ADDR_ROT), 32'h0, rd);
        cmp(rd, 32'h0);
        xfer(1'b1, 32'(ADDR_ROT), 32'h0000_0100, rd);
        xfer(1'b0, 32'h200 + 32'(80 * 4), 32'h0, rd);
        cmp(rd, 32'h0);
        xfer(1'b0, 32'h200 + 32'(72 * 4), 32'h0, rd);
        cmp(rd, 32'(tbl[72]));
        xfer(1'b1, 32'(ADDR_ROT), 32'h0000_0001, rd);
        xfer(1'b0, 32'(ADDR_ROT), 32'h0, rd);
        cmp(rd, 32'h1);
        // Purge target far from home so a stalled drive cannot count as reached
        tbl[72] = tbl[64] > 450 ? 0 : 900;
        xfer(1'b1, 32'h200 + 32'(72 * 4), 32'(tbl[72]), rd);
        repeat (200) @(posedge clk_sys);
        stall <= 1'b1;
        phase_code <= PH_PURGE;
        repeat (6) @(posedge clk_sys);
        cmp(32'(pos_cmd[CH_AIR]), 32'(DAMPER_MAX) - 32'(tbl[72]));
        wait_for(safety_shutdown);
        cmp(32'(safety_shutdown), 32'h1);
        cmp(32'(purge_timer_go), 32'h0);
        end_of_test();
    end
endmodule
